/* File: bench/brc_osc_model.sv */
// Far-side model: free-running timebase source on the crystal pin
`timescale 1ns/10ps
`default_nettype none
module brc_osc_model (
    input  wire logic run,
    output var  logic crystal_input_pin
);
    ////////////////////////////////////////////////////////////////////////
    // External oscillator at the bench link period of 80 ns; it freezes
    // when stopped, as a dead source would
    initial begin
        crystal_input_pin = 1'b0;
        forever begin
            #40;
            if (run) crystal_input_pin = ~crystal_input_pin;
        end
    end
endmodule // brc_osc_model
`default_nettype wire

/* File: bench/test_bcd_rtc_calendar_sqw.sv */
// Testbench for the BCD clock core: registers, storage, square wave, power
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    num_errors++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
module test_bcd_rtc_calendar_sqw;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        xtal;
    logic        supply;
    logic        backup;
    logic        square_wave_output_pin;
    logic        oe;
    int          num_errors = 0;
    int          num_checks = 0;
    ////////////////////////////////////////////////////////////////////////
    // Short recovery count and divider bring power and ticks within reach
    brc_rtc #(.REC_CYCLES(20), .DIV_BITS(4)) dut_u (.hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .crystal_input_pin(xtal), .vcc_above_power_fail_threshold(supply),
        .on_backup_supply(backup), .square_wave_output_pin_out(square_wave_output_pin),
        .square_wave_output_pin_oe(oe));
    brc_osc_model osc_u (.run(1'b1), .crystal_input_pin(xtal));
    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One single AHB transfer; both phases wait on hready with a bound
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h00000, a};
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        q = hrdata[7:0];
        `CHK("hresp", 1'b0, hresp)
        if (n >= 50) begin num_errors++; wrap_up(); end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string n, input logic [11:0] a,
                      input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(n, e, q)
    endtask
    // Polls status until access returns; a dry poll ends the run
    task automatic wait_access(input int lim);
        logic [7:0] q;
        int n;
        n = 0;
        do begin bus(1'b0, brc_pkg::OFF_STAT, 8'h00, q); n++; end
            while (q[brc_pkg::STAT_ACCESS_BIT] !== 1'b1 && n < lim);
        if (n >= lim) begin num_errors++; wrap_up(); end
    endtask
    task automatic toggles(input int cyc, output int t);
        logic p;
        t = 0;
        p = oe;
        repeat (cyc) begin @(posedge hclk); if (oe !== p) t++; p = oe; end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset values, hour format, storage bounds, unmapped space
    task automatic t_regs;
        wait_access(100);
        rd("sec", brc_pkg::OFF_SEC, 8'h00);
        rd("ctrl", brc_pkg::OFF_CTRL, 8'h80);
        wr(brc_pkg::OFF_HOUR, 8'h72);
        rd("hour12", brc_pkg::OFF_HOUR, 8'h72);
        wr(12'h1DC, 8'hA5);
        rd("ram55", 12'h1DC, 8'hA5);
        wr(12'h1E0, 8'h5A);
        rd("unmapped", 12'h1E0, 8'h00);
        $display("test regs done");
    endtask
    // Every rate counted over 640 cycles, then the plain driver levels
    task automatic t_sqw;
        int t;
        int e [4] = '{10, 20, 40, 160};
        for (int r = 0; r < 4; r++) begin
            wr(brc_pkg::OFF_CTRL, 8'h10 | 8'(r));
            toggles(640, t);
            `CHK("rate", 1'b1, (t >= e[r] - 1 && t <= e[r] + 1))
        end
        wr(brc_pkg::OFF_CTRL, 8'h00);
        repeat (4) @(posedge hclk);
        `CHK("out_low", 1'b1, oe)
        wr(brc_pkg::OFF_CTRL, 8'h80);
        repeat (4) @(posedge hclk);
        `CHK("out_high", 1'b0, oe)
        $display("test sqw done");
    endtask
    // One second before a rollover; a tick comes 16 crystal edges later
    task automatic t_roll(input logic [7:0] h, dt, mo, y, eh, edt, emo, ey);
        wr(brc_pkg::OFF_SEC, 8'h00);
        wr(brc_pkg::OFF_MIN, 8'h59);
        wr(brc_pkg::OFF_HOUR, h);
        wr(brc_pkg::OFF_DAY, 8'h07);
        wr(brc_pkg::OFF_DATE, dt);
        wr(brc_pkg::OFF_MONTH, mo);
        wr(brc_pkg::OFF_YEAR, y);
        wr(brc_pkg::OFF_SEC, 8'h59);
        repeat (90) @(posedge hclk);
        rd("sec_hold", brc_pkg::OFF_SEC, 8'h59);
        repeat (50) @(posedge hclk);
        rd("sec", brc_pkg::OFF_SEC, 8'h00);
        rd("min", brc_pkg::OFF_MIN, 8'h00);
        rd("hour", brc_pkg::OFF_HOUR, eh);
        rd("day", brc_pkg::OFF_DAY, 8'h01);
        rd("date", brc_pkg::OFF_DATE, edt);
        rd("month", brc_pkg::OFF_MONTH, emo);
        rd("year", brc_pkg::OFF_YEAR, ey);
        $display("test roll done");
    endtask
    // Supply loss blocks access, wave keeps running, recovery waits
    task automatic t_pwr;
        int t;
        wr(brc_pkg::OFF_CTRL, 8'h13);
        wr(12'h100, 8'h3C);
        supply <= 1'b0;
        repeat (10) @(posedge hclk);
        `CHK("backup", 1'b1, backup)
        rd("stat_fail", brc_pkg::OFF_STAT, 8'h05);
        wr(12'h100, 8'hC3);
        rd("ram_block", 12'h100, 8'h00);
        toggles(64, t);
        `CHK("sqw_bat", 1'b1, (t > 0))
        supply <= 1'b1;
        repeat (10) @(posedge hclk);
        `CHK("backup_off", 1'b0, backup)
        rd("stat_rec", brc_pkg::OFF_STAT, 8'h04);
        wait_access(20);
        rd("ram_kept", 12'h100, 8'h3C);
        $display("test pwr done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        supply = 1'b1;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_sqw();
        t_roll(8'h23, 8'h28, 8'h02, 8'h01, 8'h00, 8'h01, 8'h03, 8'h01);
        t_roll(8'h71, 8'h28, 8'h02, 8'h96, 8'h52, 8'h29, 8'h02, 8'h96);
        t_roll(8'h23, 8'h30, 8'h04, 8'h00, 8'h00, 8'h01, 8'h05, 8'h00);
        t_roll(8'h23, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h01, 8'h00);
        t_pwr();
        wrap_up();
    end
endmodule // test_bcd_rtc_calendar_sqw
`default_nettype wire

/* File: rtl/brc_bcd_inc.sv */
// Two-digit BCD increment with wrap from an upper to a lower bound
`timescale 1ns/10ps
`default_nettype none
module brc_bcd_inc (
    input  wire logic [7:0] value,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] hi,
    output var  logic [7:0] next_value,
    output var  logic       wrap
);
    // Values at or beyond the bound wrap, so bad writes recover
    always_comb begin
        wrap = (value >= hi);
        if (wrap) begin
            next_value = lo;
        end else if (value[3:0] >= 4'h9) begin
            next_value = {4'(value[7:4] + 4'h1), 4'h0};
        end else begin
            next_value = {value[7:4], 4'(value[3:0] + 4'h1)};
        end
    end
endmodule // brc_bcd_inc
`default_nettype wire

/* File: rtl/brc_pin_sync.sv */
// Three-stage synchroniser for a pin from outside the hclk domain
`timescale 1ns/10ps
`default_nettype none
module brc_pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output var  logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } brc_sync_type;

    brc_sync_type r;
    brc_sync_type next_r;

    // A change counts once stages two and three agree
    always_comb begin
        next_r     = r;
        next_r.s1  = pin;
        next_r.s2  = r.s1;
        next_r.s3  = r.s2;
        if (r.s2 == r.s3) begin
            next_r.lvl = r.s3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= {4{RESET_VAL}};
        end else begin
            r <= next_r;
        end
    end

    assign level = r.lvl;
endmodule // brc_pin_sync
`default_nettype wire

/* File: rtl/brc_pkg.sv */
// Package: constants, register map and types for the BCD RTC core
package brc_pkg;
    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int REC_TIME_MS    = 2;
    // Longest time: integer division rounds down
    localparam int REC_CYCLES     = REC_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int OSC_LOST_CYCLES = 4096;
    localparam int PRESCALE_BITS  = 15;
    localparam int TAP_1HZ        = 14;
    localparam int TAP_4K         = 2;
    localparam int TAP_8K         = 1;
    localparam int RAM_BYTES      = 56;

    // Register byte offsets (low 12 address bits decoded)
    localparam logic [11:0] OFF_SEC   = 12'h000;
    localparam logic [11:0] OFF_MIN   = 12'h004;
    localparam logic [11:0] OFF_HOUR  = 12'h008;
    localparam logic [11:0] OFF_DAY   = 12'h00C;
    localparam logic [11:0] OFF_DATE  = 12'h010;
    localparam logic [11:0] OFF_MONTH = 12'h014;
    localparam logic [11:0] OFF_YEAR  = 12'h018;
    localparam logic [11:0] OFF_CTRL  = 12'h01C;
    localparam logic [11:0] OFF_STAT  = 12'h020;
    localparam logic [11:0] OFF_RAM   = 12'h100;

    // Field positions
    localparam int HOUR_MODE12_BIT = 6;
    localparam int HOUR_PM_BIT     = 5;
    localparam int CTRL_OUT_BIT    = 7;
    localparam int CTRL_SQUARE_WAVE_ENABLE_BIT_BIT   = 4;
    localparam int CTRL_RS_LSB     = 0;
    localparam int STAT_BACKUP_BIT = 0;
    localparam int STAT_ACCESS_BIT = 1;
    localparam int STAT_OSC_BIT    = 2;
    localparam int HTRANS_ACT_BIT  = 1;

    // Reset values and BCD limits
    localparam logic [7:0] ZERO_RST   = 8'h00;
    localparam logic [7:0] ONE_RST    = 8'h01;
    localparam logic [7:0] CTRL_RST   = 8'h80;
    localparam logic [7:0] MAX_59     = 8'h59;
    localparam logic [7:0] MAX_23     = 8'h23;
    localparam logic [7:0] MAX_12     = 8'h12;
    localparam logic [7:0] HOUR_11    = 8'h11;
    localparam logic [7:0] MAX_7      = 8'h07;
    localparam logic [7:0] MAX_99     = 8'h99;
    localparam logic [7:0] MONTH_FEB  = 8'h02;
    localparam logic [7:0] DAYS_31    = 8'h31;
    localparam logic [7:0] DAYS_30    = 8'h30;
    localparam logic [7:0] DAYS_29    = 8'h29;
    localparam logic [7:0] DAYS_28    = 8'h28;

    typedef enum logic [1:0] {SQW_1HZ, SQW_4K, SQW_8K, SQW_32K} brc_sqw_type;
    typedef enum logic [1:0] {
        BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE
    } brc_bus_type;
endpackage

/* File: rtl/brc_rtc.sv */
// BCD real-time clock core with storage, square wave and AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
module brc_rtc #(
    parameter int RAM_BYTES  = brc_pkg::RAM_BYTES,
    parameter int REC_CYCLES = brc_pkg::REC_CYCLES,
    parameter int OSC_LOST   = brc_pkg::OSC_LOST_CYCLES,
    parameter int DIV_BITS   = brc_pkg::PRESCALE_BITS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic [31:0] hrdata,
    output var  logic        hresp,
    input  wire logic        crystal_input_pin,
    input  wire logic        vcc_above_power_fail_threshold,
    output var  logic        on_backup_supply,
    output var  logic        square_wave_output_pin_out,
    output var  logic        square_wave_output_pin_oe
);
    localparam int REC_W = $clog2(REC_CYCLES + 1);
    localparam int OSC_W = $clog2(OSC_LOST + 1);
    localparam logic [11:0] RAM_SPAN = 12'(RAM_BYTES * 4);

    // Elaboration check: six-bit storage index, counts, 1 Hz tap above 4k
    if (RAM_BYTES < 1 || RAM_BYTES > 64 || REC_CYCLES < 1 || OSC_LOST < 2 ||
        DIV_BITS < brc_pkg::TAP_4K + 2) begin : g_bad_param
        $error("brc_rtc: parameter out of range");
    end

    typedef struct packed {
        logic [7:0]               sec;
        logic [7:0]               min;
        logic [7:0]               hour;
        logic [7:0]               day;
        logic [7:0]               date;
        logic [7:0]               month;
        logic [7:0]               year;
        logic [7:0]               ctrl;
        logic [DIV_BITS-1:0]      prescale;
        logic                     xtal_prev;
        logic                     tick_pend;
        logic [REC_W-1:0]         rec_cnt;
        logic                     access_ok;
        logic [OSC_W-1:0]         osc_cnt;
        brc_pkg::brc_bus_type     bus;
        logic [11:0]              addr;
        logic [31:0]              rdata;
        logic                     sqw_low;
    } brc_state_type;

    brc_state_type r;
    brc_state_type next_r;
    logic [7:0]    ram [RAM_BYTES];

    logic        xtal_lvl;
    logic        vcc_ok;
    logic        xtal_rise;
    logic        tick;
    logic        adv;
    logic        osc_alive;
    logic        wr_en;
    logic        time_wr;
    logic        ram_hit;
    logic [11:0] ram_off;
    logic [5:0]  ram_idx;
    logic        leap;
    logic [7:0]  month_len;
    logic        hour_carry;
    logic        day_roll;
    logic [7:0]  hour_inc;
    logic        sqw_level;
    logic [7:0]  read_byte;
    logic [7:0]  sec_inc, min_inc, h24_inc, h12_inc;
    logic [7:0]  day_inc, date_inc, mon_inc, year_inc;
    logic        sec_wrap, min_wrap, h24_wrap, h12_wrap;
    logic        day_wrap, date_wrap, mon_wrap, year_wrap;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // External oscillator drives the crystal input; sampled, not a clock
    brc_pin_sync #(.RESET_VAL(1'b0)) u_xtal_sync (
        .hclk   (hclk),
        .hresetn(hresetn),
        .pin    (crystal_input_pin),
        .level  (xtal_lvl)
    );
    // Supply assumed failing until the comparator says otherwise
    brc_pin_sync #(.RESET_VAL(1'b0)) u_vcc_sync (
        .hclk   (hclk),
        .hresetn(hresetn),
        .pin    (vcc_above_power_fail_threshold),
        .level  (vcc_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // BCD counters of the cascade
    brc_bcd_inc u_sec (.value(r.sec), .lo(brc_pkg::ZERO_RST),
        .hi(brc_pkg::MAX_59), .next_value(sec_inc), .wrap(sec_wrap));
    brc_bcd_inc u_min (.value(r.min), .lo(brc_pkg::ZERO_RST),
        .hi(brc_pkg::MAX_59), .next_value(min_inc), .wrap(min_wrap));
    brc_bcd_inc u_h24 (.value({2'b00, r.hour[5:0]}), .lo(brc_pkg::ZERO_RST),
        .hi(brc_pkg::MAX_23), .next_value(h24_inc), .wrap(h24_wrap));
    brc_bcd_inc u_h12 (.value({3'b000, r.hour[4:0]}), .lo(brc_pkg::ONE_RST),
        .hi(brc_pkg::MAX_12), .next_value(h12_inc), .wrap(h12_wrap));
    brc_bcd_inc u_day (.value(r.day), .lo(brc_pkg::ONE_RST),
        .hi(brc_pkg::MAX_7), .next_value(day_inc), .wrap(day_wrap));
    brc_bcd_inc u_date (.value(r.date), .lo(brc_pkg::ONE_RST),
        .hi(month_len), .next_value(date_inc), .wrap(date_wrap));
    brc_bcd_inc u_mon (.value(r.month), .lo(brc_pkg::ONE_RST),
        .hi(brc_pkg::MAX_12), .next_value(mon_inc), .wrap(mon_wrap));
    brc_bcd_inc u_year (.value(r.year), .lo(brc_pkg::ZERO_RST),
        .hi(brc_pkg::MAX_99), .next_value(year_inc), .wrap(year_wrap));

    ////////////////////////////////////////////////////////////////////////
    // Calendar helpers
    always_comb begin
        // Years 00..99 are 2000..2099: every fourth year is leap
        leap = r.year[4] ? (r.year[3:0] == 4'h2 || r.year[3:0] == 4'h6)
                         : (r.year[3:0] == 4'h0 || r.year[3:0] == 4'h4 ||
                            r.year[3:0] == 4'h8);
        // Last valid date of the current month
        case (r.month)
            brc_pkg::MONTH_FEB: month_len = leap ? brc_pkg::DAYS_29
                                                 : brc_pkg::DAYS_28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = brc_pkg::DAYS_30;
            default: month_len = brc_pkg::DAYS_31;
        endcase
        // 12-hour: 11 -> 12 flips the flag, 11 PM rolls the day
        if (r.hour[brc_pkg::HOUR_MODE12_BIT]) begin
            hour_carry = (r.hour[4:0] == brc_pkg::HOUR_11[4:0]) &&
                         r.hour[brc_pkg::HOUR_PM_BIT];
            hour_inc   = {2'b01,
                          r.hour[brc_pkg::HOUR_PM_BIT] ^
                          (h12_inc == brc_pkg::MAX_12),
                          h12_inc[4:0]};
        end else begin
            hour_carry = h24_wrap;
            hour_inc   = {2'b00, h24_inc[5:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timebase, bus strobes and read mux
    always_comb begin
        xtal_rise = xtal_lvl && !r.xtal_prev;
        tick      = xtal_rise && (&r.prescale);
        osc_alive = (r.osc_cnt < OSC_W'(OSC_LOST));
        wr_en     = (r.bus == brc_pkg::BUS_WRITE) && r.access_ok;
        time_wr   = wr_en && (r.addr <= brc_pkg::OFF_YEAR);
        // A tick meeting a time write waits for the first cycle without one, never lost
        adv       = (tick || r.tick_pend) && !time_wr;
        day_roll  = adv && sec_wrap && min_wrap && hour_carry;
        ram_off   = 12'(r.addr - brc_pkg::OFF_RAM);
        ram_idx   = ram_off[7:2];
        ram_hit   = (r.addr >= brc_pkg::OFF_RAM) && (ram_off < RAM_SPAN) &&
                    (r.addr[1:0] == 2'b00);
        case (brc_pkg::brc_sqw_type'(r.ctrl[brc_pkg::CTRL_RS_LSB +: 2]))
            brc_pkg::SQW_1HZ: sqw_level = r.prescale[DIV_BITS-1];
            brc_pkg::SQW_4K:  sqw_level = r.prescale[brc_pkg::TAP_4K];
            brc_pkg::SQW_8K:  sqw_level = r.prescale[brc_pkg::TAP_8K];
            default:          sqw_level = xtal_lvl;
        endcase
        // Everything but status reads zero while access is blocked
        read_byte = 8'h00;
        case (r.addr)
            brc_pkg::OFF_SEC:   read_byte = r.sec;
            brc_pkg::OFF_MIN:   read_byte = r.min;
            brc_pkg::OFF_HOUR:  read_byte = r.hour;
            brc_pkg::OFF_DAY:   read_byte = r.day;
            brc_pkg::OFF_DATE:  read_byte = r.date;
            brc_pkg::OFF_MONTH: read_byte = r.month;
            brc_pkg::OFF_YEAR:  read_byte = r.year;
            brc_pkg::OFF_CTRL:  read_byte = r.ctrl;
            default: begin
                if (ram_hit) begin
                    read_byte = ram[ram_idx];
                end
            end
        endcase
        if (!r.access_ok) begin
            read_byte = 8'h00;
        end
        if (r.addr == brc_pkg::OFF_STAT) begin
            read_byte = 8'h00;
            read_byte[brc_pkg::STAT_BACKUP_BIT] = !vcc_ok;
            read_byte[brc_pkg::STAT_ACCESS_BIT] = r.access_ok;
            read_byte[brc_pkg::STAT_OSC_BIT]    = osc_alive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_r           = r;
        next_r.xtal_prev = xtal_lvl;
        next_r.tick_pend = (tick || r.tick_pend) && time_wr;
        // Prescaler: 32768 crystal edges make one second
        if (xtal_rise) begin
            next_r.prescale = r.prescale + 1'b1;
        end
        // Oscillator watchdog: cleared on every crystal edge
        if (xtal_lvl != r.xtal_prev) begin
            next_r.osc_cnt = '0;
        end else if (osc_alive) begin
            next_r.osc_cnt = OSC_W'(r.osc_cnt + 1'b1);
        end
        // Counting runs regardless of the supply state
        if (adv) begin
            next_r.sec = sec_inc;
            if (sec_wrap) begin
                next_r.min = min_inc;
            end
            if (sec_wrap && min_wrap) begin
                next_r.hour = hour_inc;
            end
            if (day_roll) begin
                next_r.day  = day_inc;
                next_r.date = date_inc;
                if (date_wrap) begin
                    next_r.month = mon_inc;
                end
                if (date_wrap && mon_wrap) begin
                    next_r.year = year_inc;
                end
            end
        end
        // Register writes in the data phase, only with access granted
        if (wr_en) begin
            case (r.addr)
                brc_pkg::OFF_SEC: begin
                    next_r.sec      = hwdata[7:0];
                    next_r.prescale = '0; // Fresh second starts on write
                end
                brc_pkg::OFF_MIN:   next_r.min   = hwdata[7:0];
                brc_pkg::OFF_HOUR:  next_r.hour  = hwdata[7:0];
                brc_pkg::OFF_DAY:   next_r.day   = hwdata[7:0];
                brc_pkg::OFF_DATE:  next_r.date  = hwdata[7:0];
                brc_pkg::OFF_MONTH: next_r.month = hwdata[7:0];
                brc_pkg::OFF_YEAR:  next_r.year  = hwdata[7:0];
                brc_pkg::OFF_CTRL:  next_r.ctrl  = hwdata[7:0];
                default: ;
            endcase
        end
        // Power control: block below threshold, hold off on recovery
        if (!vcc_ok) begin
            next_r.access_ok = 1'b0;
            next_r.rec_cnt   = REC_W'(REC_CYCLES);
        end else if (!r.access_ok) begin
            // No recovery wait when the oscillator has stopped
            if (r.rec_cnt == '0 || !osc_alive) begin
                next_r.access_ok = 1'b1;
            end else begin
                next_r.rec_cnt = REC_W'(r.rec_cnt - 1'b1);
            end
        end
        // Open drain: pull low for a low level, on either supply
        if (r.ctrl[brc_pkg::CTRL_SQUARE_WAVE_ENABLE_BIT_BIT]) begin
            next_r.sqw_low = !sqw_level;
        end else begin
            next_r.sqw_low = !r.ctrl[brc_pkg::CTRL_OUT_BIT];
        end
        // AHB-Lite: reads take one wait state, writes none
        if (r.bus == brc_pkg::BUS_READ_WAIT) begin
            next_r.bus   = brc_pkg::BUS_READ_DONE;
            next_r.rdata = {24'h000000, read_byte};
        end else begin
            next_r.bus = brc_pkg::BUS_IDLE;
        end
        if (hsel && htrans[brc_pkg::HTRANS_ACT_BIT] && hready) begin
            next_r.bus  = hwrite ? brc_pkg::BUS_WRITE
                                 : brc_pkg::BUS_READ_WAIT;
            next_r.addr = haddr[11:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r       <= '0;
            r.day   <= brc_pkg::ONE_RST;
            r.date  <= brc_pkg::ONE_RST;
            r.month <= brc_pkg::ONE_RST;
            r.ctrl  <= brc_pkg::CTRL_RST;
        end else begin
            r <= next_r;
        end
    end

    // Storage has no reset: contents survive on backup
    always_ff @(posedge hclk) begin
        if (wr_en && ram_hit) begin
            ram[ram_idx] <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hreadyout                  = (r.bus != brc_pkg::BUS_READ_WAIT);
    assign hrdata                     = r.rdata;
    assign hresp                      = 1'b0;
    assign on_backup_supply           = !vcc_ok;
    assign square_wave_output_pin_out = 1'b0;
    assign square_wave_output_pin_oe  = r.sqw_low;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_sec_bcd;
        adv && r.sec == 8'h09 |=> r.sec == 8'h10;
    endproperty
    a_sec_bcd: assert property (p_sec_bcd)
        else $error("seconds BCD step wrong");

    property p_min_carry;
        adv && r.sec == 8'h59 && r.min == 8'h09
            |=> r.sec == 8'h00 && r.min == 8'h10;
    endproperty
    a_min_carry: assert property (p_min_carry)
        else $error("minute carry wrong");

    property p_hour24;
        day_roll && r.hour == 8'h23 |=> r.hour == 8'h00;
    endproperty
    a_hour24: assert property (p_hour24)
        else $error("24-hour wrap wrong");

    property p_pm_flip;
        adv && sec_wrap && min_wrap && r.hour == 8'h51 |=> r.hour == 8'h72;
    endproperty
    a_pm_flip: assert property (p_pm_flip)
        else $error("12-hour afternoon flag wrong");

    property p_feb_common;
        day_roll && r.month == 8'h02 && r.date == 8'h28 && r.year == 8'h01
            |=> r.date == 8'h01 && r.month == 8'h03;
    endproperty
    a_feb_common: assert property (p_feb_common)
        else $error("February rollover wrong");

    property p_leap_day;
        day_roll && r.month == 8'h02 && r.date == 8'h28 && r.year == 8'h96
            |=> r.date == 8'h29 && r.month == 8'h02;
    endproperty
    a_leap_day: assert property (p_leap_day)
        else $error("leap day missing");

    property p_sqw_off;
        (!r.ctrl[brc_pkg::CTRL_SQUARE_WAVE_ENABLE_BIT_BIT]) [*2]
            |-> square_wave_output_pin_oe ==
                !$past(r.ctrl[brc_pkg::CTRL_OUT_BIT]);
    endproperty
    a_sqw_off: assert property (p_sqw_off)
        else $error("pin not a plain driver");

    property p_sqw_1hz;
        r.ctrl[brc_pkg::CTRL_SQUARE_WAVE_ENABLE_BIT_BIT] && r.ctrl[1:0] == 2'b00
            |=> square_wave_output_pin_oe == !$past(r.prescale[DIV_BITS-1]);
    endproperty
    a_sqw_1hz: assert property (p_sqw_1hz)
        else $error("1 Hz square wave wrong");

    property p_backup_count;
        !vcc_ok && tick && !r.tick_pend && r.sec == 8'h00 |=> r.sec == 8'h01;
    endproperty
    a_backup_count: assert property (p_backup_count)
        else $error("time stopped on backup");

    property p_refuse;
        r.bus == brc_pkg::BUS_READ_WAIT && !r.access_ok &&
            r.addr == brc_pkg::OFF_SEC |=> hrdata == 32'h00000000;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("read not refused");

    property p_recover_hold;
        $rose(vcc_ok) && osc_alive |=> (!r.access_ok) [*8];
    endproperty
    a_recover_hold: assert property (p_recover_hold)
        else $error("access granted too early");

    property p_cov_roll;
        day_roll && date_wrap;
    endproperty
    c_cov_roll: cover property (p_cov_roll);

    property p_cov_leap;
        r.month == 8'h02 && r.date == 8'h29;
    endproperty
    c_cov_leap: cover property (p_cov_leap);

    property p_cov_access;
        $rose(r.access_ok);
    endproperty
    c_cov_access: cover property (p_cov_access);
endmodule // brc_rtc
`default_nettype wire
